// File: hw/seq_pkg.sv
// Constants, encodings and register map of the program sequencer core.
// Assumes a single 20 MHz core clock and a synchronous active-high reset.
//
// Notes on behaviour
// (RL1) Four one-hot phases make one instruction cycle
// (RL2) First phase advances counter and fetches; others execute
// (RL3) Fetch of next overlaps execution of current
// (RL4) Jumps and calls take two cycles
// (RL5) Counter advances by one unless branching
// (RL6) Counter is 12 bits; only low byte addressable
// (RL7) Jump, call, interrupt, reset load target address
// (RL8) Taken skip discards prefetched word, dummy cycle
// (RL9) Low byte write jumps within page, dummy cycle
// (RL10) Return stack hidden from software, counter values only
// (RL11) Call or interrupt pushes; returns pop counter
// (RL12) Reset puts stack pointer at top
// (RL13) Full stack withholds interrupt acknowledge until return
// (RL14) Call on full stack overflows, oldest entry lost
// (RL15) Eight-bit ALU via accumulator into chosen register
// (RL16) ALU operations update carry, borrow and status
// (RL17) Add, subtract, adjust, logic, rotate, step, skips
// (RL18) Program memory is 4096 words of 16 bits
// (RL19) Table data addressed by separate table pointer
// (RL20) Execution starts at address zero after reset
// (RL21) Table read: low byte to register, high byte kept
// (RL22) Table instructions take two cycles
// (RL23) Stack depth is a constant; overflow wraps pointer

package seq_pkg;

	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int PC_W      = 12;
	localparam int DATA_W    = 8;
	localparam int INSTR_W   = 16;
	localparam int PMEM_WORDS = 4096;
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;
	localparam int CLK_HZ    = 20_000_000;

	// ****************************************
	// Vectors and reset values
	// ****************************************
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [11:0] INT_VECTOR   = 12'h004;
	localparam logic [15:0] INSTR_NOP    = 16'h0000;
	localparam logic [7:0]  BYTE_RST     = 8'h00;
	localparam logic [3:0]  TBHI_RST     = 4'h0;
	localparam logic [3:0]  STK_CNT_RST  = 4'h0;
	localparam logic [2:0]  STK_TOP_RST  = 3'h0;
	localparam logic [3:0]  STK_FULL_CNT = 4'h8;

	// ****************************************
	// Register offsets and status fields
	// ****************************************
	localparam logic [2:0] REG_PC_LOW = 3'h0;
	localparam logic [2:0] REG_TBL_LO = 3'h1;
	localparam logic [2:0] REG_TBL_HI = 3'h2;
	localparam logic [2:0] REG_TDHI   = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_ACC    = 3'h5;
	localparam int ST_C     = 0;
	localparam int ST_AC    = 1;
	localparam int ST_Z     = 2;
	localparam int ST_OV    = 3;
	localparam int ST_EMI   = 4;
	localparam int ST_IPEND = 5;
	localparam int ST_SFULL = 6;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [3:0] {
		PH_T1 = 4'b0001, PH_T2 = 4'b0010, PH_T3 = 4'b0100, PH_T4 = 4'b1000
	} phase_type;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ALUI = 4'h1, OP_ALUR = 4'h2, OP_JUMP = 4'h3,
		OP_CALL = 4'h4, OP_RETS = 4'h5, OP_IRET = 4'h6, OP_SKIP = 4'h7,
		OP_PCLA = 4'h8, OP_TABRD = 4'h9, OP_STORE = 4'hA
	} opcode_type;

	typedef enum logic [3:0] {
		FN_ADD = 4'h0, FN_ADC = 4'h1, FN_SUB = 4'h2, FN_SBC = 4'h3,
		FN_AND = 4'h4, FN_OR = 4'h5, FN_XOR = 4'h6, FN_CPL = 4'h7,
		FN_RR = 4'h8, FN_RRC = 4'h9, FN_RL = 4'hA, FN_RLC = 4'hB,
		FN_INC = 4'hC, FN_DEC = 4'hD, FN_DADJ = 4'hE, FN_MOV = 4'hF
	} alu_fn_type;

	typedef enum logic [1:0] {
		SK_Z = 2'h0, SK_NZ = 2'h1, SK_IZ = 2'h2, SK_DZ = 2'h3
	} skip_type;

endpackage : seq_pkg

// File: hw/ret_stack_mem.sv
// Return-address store: small memory with registered read data.
// Assumes one write port and one read address held stable for a cycle.
`timescale 1ns/1ns
`default_nettype none

module ret_stack_mem (
	// Clock
	input  wire logic                          clk_i,
	// Write side
	input  wire logic                          wr_en_i,
	input  wire logic [seq_pkg::STK_PTR_W-1:0] wr_addr_i,
	input  wire logic [seq_pkg::PC_W-1:0]      wr_data_i,
	// Read side
	input  wire logic [seq_pkg::STK_PTR_W-1:0] rd_addr_i,
	output logic      [seq_pkg::PC_W-1:0]      rd_data_o
);

	logic [seq_pkg::PC_W-1:0] mem_r [seq_pkg::STK_DEPTH];

	// ****************************************
	// Storage
	// ****************************************
	// No reset: contents are meaningless until pushed
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read, settles well before the execute phase
	always_ff @(posedge clk_i) begin
		rd_data_o <= mem_r[rd_addr_i];
	end

endmodule : ret_stack_mem

`default_nettype wire

// File: hw/program_sequencer_core.sv
// Program sequencer core: phase generator, fetch/execute pipeline,
// program counter, return stack, ALU and table reads.
// Assumes a synchronous program memory answering by the fourth phase,
// and an interrupt request from logic on the same clock.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module program_sequencer_core (
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        SYS_RST_I,
	// Register port
	input  wire logic [2:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [7:0]  REG_RDATA_O,
	// Program memory
	output logic      [11:0] PMEM_ADDR_O,
	output logic             PMEM_RD_O,
	input  wire logic [15:0] PMEM_DATA_I,
	// Interrupt
	input  wire logic        INT_REQ_I,
	output logic             INT_ACK_O,
	// Observation
	output logic      [3:0]  PHASE_O,
	output logic      [11:0] PC_O
);

	// ****************************************
	// Declarations
	// ****************************************
	seq_pkg::phase_type  phase_r;
	seq_pkg::opcode_type op;
	seq_pkg::alu_fn_type fn;
	seq_pkg::skip_type   sk;
	logic [11:0] pc_r;
	logic [15:0] ir_r;
	logic [15:0] hold_r;
	logic        tab_cyc_r;
	logic [1:0]  tab_dst_r;
	logic [7:0]  acc_r;
	logic [7:0]  wreg_r [4];
	logic        c_r;
	logic        ac_r;
	logic        z_r;
	logic        ov_r;
	logic        emi_r;
	logic        int_pend_r;
	logic        plo_req_r;
	logic [7:0]  plo_wdata_r;
	logic [7:0]  tbl_lo_r;
	logic [3:0]  tbl_hi_r;
	logic [7:0]  tdhi_r;
	logic [2:0]  stk_top_r;
	logic [3:0]  stk_cnt_r;
	logic [11:0] stk_rdata;
	logic        stk_full;
	logic        t1;
	logic        t4;
	logic [7:0]  wval;
	logic [7:0]  operand;
	logic [10:0] alu_out;
	logic [7:0]  skip_val;
	logic        skip_hit;
	logic        redirect;
	logic [11:0] target;
	logic        push;
	logic        pop;
	logic        take_int;
	logic        flush;
	logic        plo_take;

	// Unary functions act on the operand alone
	function automatic logic is_unary(input seq_pkg::alu_fn_type f);
		is_unary = f inside {seq_pkg::FN_CPL, seq_pkg::FN_RR, seq_pkg::FN_RRC,
			seq_pkg::FN_RL, seq_pkg::FN_RLC, seq_pkg::FN_INC, seq_pkg::FN_DEC,
			seq_pkg::FN_DADJ};
	endfunction : is_unary

	// Result in [7:0], carry [8], half carry [9], overflow [10]
	function automatic logic [10:0] alu_calc(input seq_pkg::alu_fn_type f,
		input logic [7:0] a, input logic [7:0] b, input logic ci, input logic aci);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] bb;
		logic       ov;
		s  = {ci, b};
		h  = {aci, 4'h0};
		bb = b;
		ov = 1'b0;
		unique case (f)
			seq_pkg::FN_ADD, seq_pkg::FN_ADC: begin
				s = {1'b0, a} + {1'b0, b} + {8'h00, ci & (f == seq_pkg::FN_ADC)};
				h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci & (f == seq_pkg::FN_ADC)};
			end
			seq_pkg::FN_SUB, seq_pkg::FN_SBC: begin
				bb = ~b;
				s  = {1'b0, a} + {1'b0, bb} + {8'h00, (f == seq_pkg::FN_SUB) | ci};
				h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (f == seq_pkg::FN_SUB) | ci};
			end
			seq_pkg::FN_AND: s = {ci, a & b};
			seq_pkg::FN_OR:  s = {ci, a | b};
			seq_pkg::FN_XOR: s = {ci, a ^ b};
			seq_pkg::FN_CPL: s = {ci, ~b};
			seq_pkg::FN_RR:  s = {ci, b[0], b[7:1]};
			seq_pkg::FN_RRC: s = {b[0], ci, b[7:1]};
			seq_pkg::FN_RL:  s = {ci, b[6:0], b[7]};
			seq_pkg::FN_RLC: s = {b[7], b[6:0], ci};
			seq_pkg::FN_INC: s = {ci, b + 8'h01};
			seq_pkg::FN_DEC: s = {ci, b - 8'h01};
			seq_pkg::FN_DADJ: begin
				s = {1'b0, b};
				if (b[3:0] > 4'h9 || aci) begin
					s = s + 9'h006;
				end
				if (s[7:4] > 4'h9 || ci || s[8]) begin
					s = s + 9'h060;
				end
				s[8] = s[8] | ci;
			end
			seq_pkg::FN_MOV: s = {ci, b};
		endcase
		if (f inside {seq_pkg::FN_ADD, seq_pkg::FN_ADC, seq_pkg::FN_SUB, seq_pkg::FN_SBC}) begin
			ov = (a[7] == bb[7]) && (s[7] != a[7]);
		end
		alu_calc = {ov, h[4], s};
	endfunction : alu_calc

	// ****************************************
	// Phase generator
	// ****************************************
	// One phase per clock, four phases per instruction cycle
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			phase_r <= seq_pkg::PH_T1;
		end else begin
			unique case (phase_r)   // see RL1
				seq_pkg::PH_T1: phase_r <= seq_pkg::PH_T2;
				seq_pkg::PH_T2: phase_r <= seq_pkg::PH_T3;
				seq_pkg::PH_T3: phase_r <= seq_pkg::PH_T4;
				seq_pkg::PH_T4: phase_r <= seq_pkg::PH_T1;
			endcase
		end
	end

	assign t1      = (phase_r == seq_pkg::PH_T1);
	assign t4      = (phase_r == seq_pkg::PH_T4);
	assign PHASE_O = phase_r;
	assign PC_O    = pc_r;

	// ****************************************
	// Decode and execute
	// ****************************************
	// Everything here is acted on at the end of the fourth phase
	always_comb begin
		op       = seq_pkg::opcode_type'(ir_r[15:12]);
		fn       = seq_pkg::alu_fn_type'(ir_r[11:8]);
		sk       = seq_pkg::skip_type'(ir_r[9:8]);
		wval     = wreg_r[ir_r[1:0]];
		operand  = (op == seq_pkg::OP_ALUI) ? (is_unary(fn) ? acc_r : ir_r[7:0]) : wval;
		alu_out  = alu_calc(fn, acc_r, operand, c_r, ac_r);   // see RL15
		skip_val = (sk == seq_pkg::SK_IZ) ? wval + 8'h01 :
			(sk == seq_pkg::SK_DZ) ? wval - 8'h01 : wval;
		skip_hit = 1'b0;
		redirect = 1'b0;
		target   = pc_r;
		push     = 1'b0;
		pop      = 1'b0;
		plo_take = 1'b0;
		unique case (op)
			seq_pkg::OP_JUMP, seq_pkg::OP_CALL: begin
				redirect = 1'b1;   // see RL4
				target   = ir_r[11:0];   // see RL7
				push     = (op == seq_pkg::OP_CALL);   // see RL11
			end
			seq_pkg::OP_RETS, seq_pkg::OP_IRET: begin
				redirect = 1'b1;
				target   = stk_rdata;   // see RL11
				pop      = 1'b1;
			end
			seq_pkg::OP_SKIP: skip_hit = (sk == seq_pkg::SK_NZ) ?
				(skip_val != 8'h00) : (skip_val == 8'h00);   // see RL8
			seq_pkg::OP_PCLA: begin
				redirect = 1'b1;
				target   = {pc_r[11:8], acc_r};   // see RL9
			end
			default: ;
		endcase
		// A low byte write from the port jumps like an instruction would
		if (!redirect && plo_req_r) begin
			redirect = 1'b1;
			plo_take = 1'b1;
			target   = {pc_r[11:8], plo_wdata_r};   // see RL9
		end
		// Held off while the stack is full, so an interrupt never overwrites an entry
		take_int = !tab_cyc_r && !redirect && !skip_hit && op != seq_pkg::OP_TABRD &&
			int_pend_r && emi_r && !stk_full;   // see RL13
		push  = push | take_int;   // see RL11
		flush = redirect | skip_hit | take_int;
	end

	// ****************************************
	// Program counter and fetch
	// ****************************************
	// Counter steps at the first phase unless a table word is fetched
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			pc_r <= seq_pkg::RESET_VECTOR;   // see RL20
		end else if (t1 && !tab_cyc_r) begin
			pc_r <= pc_r + 12'h001;   // see RL2, RL5
		end else if (t4 && !tab_cyc_r) begin
			if (take_int) begin
				pc_r <= seq_pkg::INT_VECTOR;   // see RL7
			end else if (redirect) begin
				pc_r <= target;   // see RL7
			end
		end
	end

	// Address the memory with the counter or the table pointer
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			PMEM_ADDR_O <= seq_pkg::RESET_VECTOR;
			PMEM_RD_O   <= 1'b0;
		end else begin
			PMEM_RD_O <= t1;   // see RL2
			if (t1) begin
				PMEM_ADDR_O <= tab_cyc_r ? {tbl_hi_r, tbl_lo_r} : pc_r;   // see RL18, RL19
			end
		end
	end

	// ****************************************
	// Pipeline register
	// ****************************************
	// Prefetched word becomes next instruction, or a dummy on a flush
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			ir_r      <= seq_pkg::INSTR_NOP;
			hold_r    <= seq_pkg::INSTR_NOP;
			tab_cyc_r <= 1'b0;
			tab_dst_r <= 2'h0;
		end else if (t4) begin
			if (tab_cyc_r) begin
				ir_r      <= hold_r;   // see RL22
				tab_cyc_r <= 1'b0;
			end else if (op == seq_pkg::OP_TABRD) begin
				hold_r    <= PMEM_DATA_I;
				ir_r      <= seq_pkg::INSTR_NOP;
				tab_cyc_r <= 1'b1;   // see RL22
				tab_dst_r <= ir_r[1:0];
			end else if (flush) begin
				ir_r <= seq_pkg::INSTR_NOP;   // see RL8, RL9
			end else begin
				ir_r <= PMEM_DATA_I;   // see RL3
			end
		end
	end

	// ****************************************
	// Return stack
	// ****************************************
	// Count saturates at depth while the pointer wraps over the oldest
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			stk_top_r <= seq_pkg::STK_TOP_RST;   // see RL12
			stk_cnt_r <= seq_pkg::STK_CNT_RST;
		end else if (t4 && !tab_cyc_r) begin
			if (push) begin
				stk_top_r <= stk_top_r + 3'h1;   // see RL14, RL23
				stk_cnt_r <= stk_full ? stk_cnt_r : stk_cnt_r + 4'h1;
			end else if (pop) begin
				stk_top_r <= stk_top_r - 3'h1;
				stk_cnt_r <= (stk_cnt_r != 4'h0) ? stk_cnt_r - 4'h1 : stk_cnt_r;
			end
		end
	end

	assign stk_full = (stk_cnt_r == seq_pkg::STK_FULL_CNT);

	// Only the sequencer reaches this store, never the register port
	ret_stack_mem u_stack (
		.clk_i     (CORE_CLK_I),
		.wr_en_i   (t4 && !tab_cyc_r && push),   // see RL10
		.wr_addr_i (stk_top_r),
		.wr_data_i (pc_r - 12'h001),
		.rd_addr_i (stk_top_r - 3'h1),
		.rd_data_o (stk_rdata)
	);

	// ****************************************
	// Accumulator, work registers and flags
	// ****************************************
	// Results land in the accumulator or the named work register
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			acc_r <= seq_pkg::BYTE_RST;
			for (int i = 0; i < 4; i++) begin
				wreg_r[i] <= seq_pkg::BYTE_RST;
			end
		end else if (t4 && tab_cyc_r) begin
			wreg_r[tab_dst_r] <= PMEM_DATA_I[7:0];   // see RL21
		end else if (t4) begin
			unique case (op)
				seq_pkg::OP_ALUI: acc_r <= alu_out[7:0];
				seq_pkg::OP_ALUR: begin
					if (ir_r[3]) begin
						wreg_r[ir_r[1:0]] <= alu_out[7:0];   // see RL15
					end else begin
						acc_r <= alu_out[7:0];
					end
				end
				seq_pkg::OP_STORE: wreg_r[ir_r[1:0]] <= acc_r;
				seq_pkg::OP_SKIP: wreg_r[ir_r[1:0]] <= skip_val;   // see RL17
				default: ;
			endcase
		end else if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_ACC) begin
			acc_r <= REG_WDATA_I;
		end
	end

	// Status follows every ALU instruction result; the skip steps leave it untouched
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			c_r  <= 1'b0;
			ac_r <= 1'b0;
			z_r  <= 1'b0;
			ov_r <= 1'b0;
		end else if (t4 && (op == seq_pkg::OP_ALUI || op == seq_pkg::OP_ALUR)) begin
			c_r  <= alu_out[8];   // see RL16
			ac_r <= alu_out[9];
			z_r  <= (alu_out[7:0] == 8'h00);
			ov_r <= alu_out[10];
		end
	end

	// ****************************************
	// Interrupt request and enable
	// ****************************************
	// A new request wins over the clear by acknowledge
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			int_pend_r <= 1'b0;
			emi_r      <= 1'b0;
			INT_ACK_O  <= 1'b0;
		end else begin
			INT_ACK_O  <= t4 && take_int;   // see RL13
			int_pend_r <= (int_pend_r && !(t4 && take_int)) || INT_REQ_I;
			if (t4 && take_int) begin
				emi_r <= 1'b0;
			end else if (t4 && op == seq_pkg::OP_IRET) begin
				emi_r <= 1'b1;
			end else if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_STATUS) begin
				emi_r <= REG_WDATA_I[seq_pkg::ST_EMI];
			end
		end
	end

	// ****************************************
	// Register port writes
	// ****************************************
	// Low byte write waits for the next execute edge; a new write wins
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			plo_req_r   <= 1'b0;
			plo_wdata_r <= seq_pkg::BYTE_RST;
		end else if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_PC_LOW) begin
			plo_req_r   <= 1'b1;   // see RL6
			plo_wdata_r <= REG_WDATA_I;
		end else if (t4 && !tab_cyc_r && plo_take) begin
			plo_req_r <= 1'b0;
		end
	end

	// Table pointer and table high byte
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			tbl_lo_r <= seq_pkg::BYTE_RST;
			tbl_hi_r <= seq_pkg::TBHI_RST;
			tdhi_r   <= seq_pkg::BYTE_RST;
		end else begin
			if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_TBL_LO) begin
				tbl_lo_r <= REG_WDATA_I;   // see RL19
			end
			if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_TBL_HI) begin
				tbl_hi_r <= REG_WDATA_I[3:0];
			end
			// Hardware load takes priority over a same-cycle port write
			if (t4 && tab_cyc_r) begin
				tdhi_r <= PMEM_DATA_I[15:8];   // see RL21
			end else if (REG_WR_I && REG_ADDR_I == seq_pkg::REG_TDHI) begin
				tdhi_r <= REG_WDATA_I;
			end
		end
	end

	// ****************************************
	// Register port reads
	// ****************************************
	// Data stands only in the cycle after the strobe
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O <= seq_pkg::BYTE_RST;
		end else if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				seq_pkg::REG_PC_LOW: REG_RDATA_O <= pc_r[7:0];   // see RL6
				seq_pkg::REG_TBL_LO: REG_RDATA_O <= tbl_lo_r;
				seq_pkg::REG_TBL_HI: REG_RDATA_O <= {4'h0, tbl_hi_r};
				seq_pkg::REG_TDHI:   REG_RDATA_O <= tdhi_r;
				seq_pkg::REG_STATUS: REG_RDATA_O <= {1'b0, stk_full, int_pend_r, emi_r,
					ov_r, z_r, ac_r, c_r};
				seq_pkg::REG_ACC:    REG_RDATA_O <= acc_r;
				default:             REG_RDATA_O <= 8'h00;
			endcase
		end else begin
			REG_RDATA_O <= 8'h00;
		end
	end

endmodule : program_sequencer_core

`default_nettype wire

// File: verif/seq_core_properties.sv
// Port-level checks for the program sequencer core.
// Assumes binding onto the core top; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none

module seq_core_checker (
	// Clock and reset
	input wire logic        CORE_CLK_I,
	input wire logic        SYS_RST_I,
	// Observed ports
	input wire logic        REG_RD_I,
	input wire logic [7:0]  REG_RDATA_O,
	input wire logic [11:0] PMEM_ADDR_O,
	input wire logic        PMEM_RD_O,
	input wire logic        INT_ACK_O,
	input wire logic [3:0]  PHASE_O,
	input wire logic [11:0] PC_O
);
	logic rst_d_r;

	// Delayed reset marks the release edge
	always_ff @(posedge CORE_CLK_I) begin
		rst_d_r <= SYS_RST_I;
	end

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// ****
	// Phase walk
	// ****
	sequence s_exec;
		(PHASE_O == 4'h2) ##1 (PHASE_O == 4'h4) ##1 (PHASE_O == 4'h8);
	endsequence
	sequence s_cycle;
		s_exec ##1 (PHASE_O == 4'h1);
	endsequence

	property p_phase_walk;
		(PHASE_O == 4'h1) |=> s_cycle;
	endproperty
	a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");

	property p_fetch_t2;
		(PHASE_O == 4'h1) |=> PMEM_RD_O ##1 !PMEM_RD_O [*3];
	endproperty
	a_fetch_t2: assert property (p_fetch_t2) else $error("fetch pulse misplaced");

	// A table fetch uses the pointer and leaves the counter alone
	property p_fetch_addr;
		PMEM_RD_O |-> (PC_O == PMEM_ADDR_O + 12'h001) || $stable(PC_O);
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not at pc");

	property p_addr_hold;
		(PHASE_O != 4'h1) |=> $stable(PMEM_ADDR_O);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");

	// Mid-cycle phases never touch the counter
	property p_pc_quiet;
		(PHASE_O == 4'h2 || PHASE_O == 4'h4) |=> $stable(PC_O);
	endproperty
	a_pc_quiet: assert property (p_pc_quiet) else $error("pc moved mid cycle");

	property p_ack_vec;
		INT_ACK_O |-> (PC_O == seq_pkg::INT_VECTOR) && (PHASE_O == 4'h1);
	endproperty
	a_ack_vec: assert property (p_ack_vec) else $error("ack without vector");

	property p_ack_gap;
		INT_ACK_O |=> !INT_ACK_O [*4];
	endproperty
	a_ack_gap: assert property (p_ack_gap) else $error("ack too long");

	property p_rd_idle;
		!REG_RD_I |=> (REG_RDATA_O == 8'h00);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

	property p_reset_start;
		(rst_d_r && !SYS_RST_I) |-> (PC_O == 12'h000) ##1 (PC_O == 12'h001);
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("bad start");
endmodule : seq_core_checker

bind program_sequencer_core seq_core_checker u_chk (
	.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .PMEM_ADDR_O(PMEM_ADDR_O), .PMEM_RD_O(PMEM_RD_O),
	.INT_ACK_O(INT_ACK_O), .PHASE_O(PHASE_O), .PC_O(PC_O)
);

`default_nettype wire

// File: verif/pmem_model.sv
// Behavioural program memory answering the core's fetches.
// Assumes one fetch pulse per cycle and data used at the fourth phase.
`timescale 1ns/1ns
`default_nettype none

module pmem_model #(
	parameter bit SLOW = 1'b1
) (
	// Clock
	input  wire logic        clk_i,
	// Fetch side
	input  wire logic        rd_i,
	input  wire logic [11:0] addr_i,
	output logic      [15:0] data_o
);
	logic [15:0] mem [0:4095];
	logic [11:0] addr_r;
	logic [1:0]  age_r;

	// Slow mode answers at the last legal edge; stale data is garbled
	always_ff @(posedge clk_i) begin
		if (rd_i) begin
			addr_r <= addr_i;
			age_r  <= 2'h0;
			data_o <= SLOW ? ~mem[addr_i] : mem[addr_i];
		end else begin
			age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
			if (age_r == 2'h0) begin
				data_o <= mem[addr_r];
			end else if (age_r == 2'h2) begin
				data_o <= ~data_o;
			end
		end
	end
endmodule : pmem_model

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the program sequencer core.
// Assumes core, package, memory model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        clk;
	logic        rst;
	logic [2:0]  ra;
	logic [7:0]  wd;
	logic        wr;
	logic        rd;
	logic [7:0]  rdat;
	logic [11:0] paddr;
	logic        prd;
	logic [15:0] pdat;
	logic        irq;
	logic        ack;
	logic [3:0]  phase;
	logic [11:0] pc;
	logic [8:0]  sum;
	int          fail_count;
	int          num_checks;
	int          cycles;

	program_sequencer_core uut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ra),
		.REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
		.PMEM_ADDR_O(paddr), .PMEM_RD_O(prd), .PMEM_DATA_I(pdat), .INT_REQ_I(irq),
		.INT_ACK_O(ack), .PHASE_O(phase), .PC_O(pc));
	pmem_model #(.SLOW(1'b1)) u_pmem (.clk_i(clk), .rd_i(prd), .addr_i(paddr), .data_o(pdat));

	// ****
	// Clock and hang guard
	// ****
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count = fail_count + 1;
			close_out();
		end
	end

	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		ra <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check({8'h00, rdat}, {8'h00, exp});
	endtask : reg_rd

	task automatic wait_pc(input logic [11:0] t);
		for (int i = 0; i < 80 && pc !== t; i++) begin
			@(posedge clk);
			#1;
		end
		check({4'h0, pc}, {4'h0, t});
	endtask : wait_pc

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		repeat (4) @(posedge clk);
		check({4'h0, pc}, 16'h0000);
		check({12'h000, phase}, 16'h0001);
		rst <= 1'b0;
		@(posedge clk);
		#1 check({4'h0, pc}, 16'h0001);
	endtask : t_reset

	// Straight code, jump across pages, table read, call and return
	task automatic t_program();
		sum = 9'h0EA + 9'h030;
		wait_pc(12'h124);
		reg_rd(seq_pkg::REG_ACC, sum[7:0]);
		reg_rd(seq_pkg::REG_STATUS, {7'h00, sum[8]});
		reg_rd(seq_pkg::REG_TDHI, 8'h1F);
	endtask : t_program

	task automatic t_regs();
		reg_wr(seq_pkg::REG_TBL_HI, 8'hFF);
		reg_rd(seq_pkg::REG_TBL_HI, 8'h0F);
		reg_wr(3'h7, 8'hAA);
		reg_rd(3'h7, 8'h00);
		reg_rd(3'h6, 8'h00);
	endtask : t_regs

	task automatic t_irq();
		reg_wr(seq_pkg::REG_STATUS, 8'h10);
		reg_rd(seq_pkg::REG_STATUS, {3'h0, 1'b1, 3'h0, sum[8]});
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		for (int i = 0; i < 24 && ack !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		check({15'h0000, ack}, 16'h0001);
		check({4'h0, pc}, {4'h0, seq_pkg::INT_VECTOR});
		wait_pc(12'h124);
		reg_rd(seq_pkg::REG_STATUS, {3'h0, 1'b1, 3'h0, sum[8]});
	endtask : t_irq

	// Low byte write stays inside the current page; target calls itself
	task automatic t_page();
		reg_wr(seq_pkg::REG_PC_LOW, 8'h40);
		wait_pc({pc[11:8], 8'h41});
		check({4'h0, pc}, 16'h0141);
	endtask : t_page

	// Self-call overflows the stack; an interrupt must stay pending
	task automatic t_full();
		int acks;
		acks = 0;
		repeat (100) @(posedge clk);
		irq <= 1'b1;
		repeat (24) begin
			@(posedge clk);
			irq <= 1'b0;
			#1 acks = acks + ((ack === 1'b1) ? 1 : 0);
		end
		check(acks[15:0], 16'h0000);
		reg_rd(seq_pkg::REG_STATUS, {1'b0, 3'h7, 3'h0, sum[8]});
	endtask : t_full

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// ****
	// Main sequence
	// ****
	initial begin
		rst = 1'b1;
		ra = 3'h0;
		wd = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		irq = 1'b0;
		for (int i = 0; i < 4096; i++) begin
			u_pmem.mem[i] = 16'h0000;
		end
		u_pmem.mem[12'h000] = 16'h1F5A;
		u_pmem.mem[12'h001] = 16'h1090;
		u_pmem.mem[12'h002] = 16'h1030;
		u_pmem.mem[12'h003] = 16'h3120;
		u_pmem.mem[12'h004] = 16'h6000;
		u_pmem.mem[12'h030] = 16'h5000;
		u_pmem.mem[12'h120] = 16'h9000;
		u_pmem.mem[12'h121] = 16'h4030;
		u_pmem.mem[12'h123] = 16'h3122;
		u_pmem.mem[12'h140] = 16'h4140;
		t_reset();
		t_program();
		t_regs();
		t_irq();
		t_page();
		t_full();
		close_out();
	end
endmodule : tb

`default_nettype wire
